// ---- verilog/pfs_pkg.sv ----
package pfs_pkg;
   localparam logic [11:0] PFS_SEL_OFFSET = 12'h000;
   localparam logic [15:0] PFS_SEL_RESET  = 16'h0000;
   localparam int          PFS_P11_LSB    = 12;
   localparam int          PFS_P10_LSB    = 8;
   localparam int          PFS_P9_LSB     = 4;
   localparam int          PFS_P8_LSB     = 0;
   localparam logic [2:0]  PFS_FLD_RESET  = 3'h0;

   typedef enum logic [2:0] {
      PFS_MD_PORT  = 3'h0,
      PFS_MD_CS    = 3'h1,
      PFS_MD_PROH  = 3'h2,
      PFS_MD_IRQ   = 3'h3,
      PFS_MD_TCAP  = 3'h4,
      PFS_MD_CAN   = 3'h5,
      PFS_MD_UART  = 3'h6,
      PFS_MD_ETH   = 3'h7
   } pfs_mode_t;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } pfs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } pfs_apb_rsp_t;

   typedef struct packed {
      logic [2:0] pin11_function_field;
      logic [2:0] pin10_function_field;
      logic [2:0] pin9_function_field;
      logic [2:0] pin8_function_field;
   } pfs_fields_t;
endpackage : pfs_pkg

// ---- verilog/pfs_sel_reg.sv ----
`timescale 1ns/10ps
module pfs_sel_reg (
   // Clock and reset.
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // Register bus.
   input  wire pfs_pkg::pfs_apb_req_t apb_req,
   output pfs_pkg::pfs_apb_rsp_t      apb_rsp,
   // Fields.
   output pfs_pkg::pfs_fields_t       fields
);
   import pfs_pkg::*;

   typedef struct packed {
      pfs_fields_t f;
      logic [31:0] rdata;
   } pfs_reg_state_t;

   pfs_reg_state_t st_ff;
   pfs_reg_state_t nxt_st;
   logic           hit;
   logic [15:0]    img;

   assign hit = (apb_req.paddr[11:0] == PFS_SEL_OFFSET) && (apb_req.paddr[31:12] == 20'h00000);
   assign img = {1'b0, st_ff.f.pin11_function_field, 1'b0, st_ff.f.pin10_function_field,
                 1'b0, st_ff.f.pin9_function_field, 1'b0, st_ff.f.pin8_function_field};

   always_comb begin
      nxt_st = st_ff;
      if (apb_req.psel && !apb_req.penable) begin
         nxt_st.rdata = hit ? {16'h0000, img} : 32'h00000000;
      end
      if (apb_req.psel && apb_req.penable && apb_req.pwrite && hit) begin
         nxt_st.f.pin11_function_field = apb_req.pwdata[PFS_P11_LSB +: 3];
         nxt_st.f.pin10_function_field = apb_req.pwdata[PFS_P10_LSB +: 3];
         nxt_st.f.pin9_function_field  = apb_req.pwdata[PFS_P9_LSB +: 3];
         nxt_st.f.pin8_function_field  = apb_req.pwdata[PFS_P8_LSB +: 3];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{f: '{PFS_FLD_RESET, PFS_FLD_RESET, PFS_FLD_RESET, PFS_FLD_RESET},
                    rdata: 32'h00000000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign apb_rsp.prdata  = st_ff.rdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit;
   assign fields          = st_ff.f;
endmodule : pfs_sel_reg

// ---- verilog/pfs_top.sv ----
`timescale 1ns/10ps
module pfs_top (
   // Clock and reset.
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // Register bus.
   input  wire pfs_pkg::pfs_apb_req_t apb_req,
   output pfs_pkg::pfs_apb_rsp_t      apb_rsp,
   // Pin 11 pad.
   input  wire logic                  pin11_in,
   output logic                       pin11_out,
   output logic                       pin11_oe,
   // Pin 10 pad.
   input  wire logic                  pin10_in,
   output logic                       pin10_out,
   output logic                       pin10_oe,
   // General port side.
   input  wire logic                  port_pin_11_out,
   input  wire logic                  port_pin_11_oe,
   output logic                       port_pin_11_in,
   input  wire logic                  port_pin_10_out,
   input  wire logic                  port_pin_10_oe,
   output logic                       port_pin_10_in,
   // Peripheral outputs.
   input  wire logic                  chip_select_1,
   input  wire logic                  chip_select_2,
   input  wire logic                  can_transmit,
   input  wire logic                  uart_transmit,
   input  wire logic                  ethernet_transmit_data_bit0,
   // Peripheral inputs.
   output logic                       interrupt_request_1,
   output logic                       interrupt_request_2,
   output logic                       timer_capture_input_v,
   output logic                       timer_capture_input_w,
   output logic                       can_receive,
   output logic                       uart_receive,
   output logic                       ethernet_transmit_enable,
   // Mode fields.
   output pfs_pkg::pfs_fields_t       fields
);
   import pfs_pkg::*;

   // Pad inputs pass three flops; a change counts when stages two and three agree.
   typedef struct packed {
      logic [2:0] s11;
      logic [2:0] s10;
      logic       v11;
      logic       v10;
   } pfs_sync_t;

   pfs_sync_t sy_ff;
   pfs_sync_t nxt_sy;
   pfs_mode_t m11;
   pfs_mode_t m10;

   pfs_sel_reg u_reg (
      .mclk    (mclk),
      .rstn    (rstn),
      .apb_req (apb_req),
      .apb_rsp (apb_rsp),
      .fields  (fields)
   );

   assign m11 = pfs_mode_t'(fields.pin11_function_field);
   assign m10 = pfs_mode_t'(fields.pin10_function_field);

   always_comb begin
      nxt_sy     = sy_ff;
      nxt_sy.s11 = {sy_ff.s11[1:0], pin11_in};
      nxt_sy.s10 = {sy_ff.s10[1:0], pin10_in};
      if (sy_ff.s11[1] == sy_ff.s11[2]) begin
         nxt_sy.v11 = sy_ff.s11[2];
      end
      if (sy_ff.s10[1] == sy_ff.s10[2]) begin
         nxt_sy.v10 = sy_ff.s10[2];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sy_ff <= '0;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   // Pin 11 routing; an unselected peripheral input rests at its idle level.
   always_comb begin
      pin11_out                = 1'b0;
      pin11_oe                 = 1'b0;
      interrupt_request_1      = 1'b0;
      timer_capture_input_v    = 1'b0;
      can_receive              = 1'b1;
      uart_receive             = 1'b1;
      ethernet_transmit_enable = 1'b0;

      case (m11)
         PFS_MD_PORT: begin
            pin11_out = port_pin_11_out;
            pin11_oe  = port_pin_11_oe;
         end

         PFS_MD_CS: begin
            pin11_out = chip_select_1;
            pin11_oe  = 1'b1;
         end

         PFS_MD_PROH: begin
            pin11_out = 1'b0;
            pin11_oe  = 1'b0;
         end

         PFS_MD_IRQ: begin
            interrupt_request_1 = sy_ff.v11;
         end

         PFS_MD_TCAP: begin
            timer_capture_input_v = sy_ff.v11;
         end

         PFS_MD_CAN: begin
            can_receive = sy_ff.v11;
         end

         PFS_MD_UART: begin
            uart_receive = sy_ff.v11;
         end

         PFS_MD_ETH: begin
            ethernet_transmit_enable = sy_ff.v11;
         end

         default: begin
            pin11_out = 1'b0;
            pin11_oe  = 1'b0;
         end
      endcase
   end

   assign port_pin_11_in = sy_ff.v11;

   // Pin 10 routing; the pad is only driven for the output codes.
   always_comb begin
      pin10_out             = 1'b0;
      pin10_oe              = 1'b0;
      interrupt_request_2   = 1'b0;
      timer_capture_input_w = 1'b0;

      case (m10)
         PFS_MD_PORT: begin
            pin10_out = port_pin_10_out;
            pin10_oe  = port_pin_10_oe;
         end

         PFS_MD_CS: begin
            pin10_out = chip_select_2;
            pin10_oe  = 1'b1;
         end

         PFS_MD_PROH: begin
            pin10_out = 1'b0;
            pin10_oe  = 1'b0;
         end

         PFS_MD_IRQ: begin
            interrupt_request_2 = sy_ff.v10;
         end

         PFS_MD_TCAP: begin
            timer_capture_input_w = sy_ff.v10;
         end

         PFS_MD_CAN: begin
            pin10_out = can_transmit;
            pin10_oe  = 1'b1;
         end

         PFS_MD_UART: begin
            pin10_out = uart_transmit;
            pin10_oe  = 1'b1;
         end

         PFS_MD_ETH: begin
            pin10_out = ethernet_transmit_data_bit0;
            pin10_oe  = 1'b1;
         end

         default: begin
            pin10_out = 1'b0;
            pin10_oe  = 1'b0;
         end
      endcase
   end

   assign port_pin_10_in = sy_ff.v10;
endmodule : pfs_top

// ---- verif/pfs_peer.sv ----
`timescale 1ns/10ps
module pfs_peer (
   // Clock, reset and levels.
   input  wire logic       mclk,
   input  wire logic       rstn,
   output logic      [6:0] lvl
);
   // Bits 6 and 5 are the pad levels; bit 5 changes every 32 cycles and bit 6 every 64 cycles.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lvl <= 7'h00;
      end else begin
         lvl <= lvl + 7'h01;
      end
   end
endmodule : pfs_peer

// ---- verif/pfs_top_properties.sv ----
`timescale 1ns/10ps
module pfs_chk (
   // Clock and reset.
   input wire logic                  mclk,
   input wire logic                  rstn,
   // Watched ports.
   input wire pfs_pkg::pfs_apb_req_t apb_req,
   input wire pfs_pkg::pfs_apb_rsp_t apb_rsp,
   input wire pfs_pkg::pfs_fields_t  fields,
   input wire logic                  pin11_oe,
   input wire logic                  pin11_out,
   input wire logic                  pin10_oe,
   input wire logic                  pin10_out,
   input wire logic                  chip_select_1,
   input wire logic                  chip_select_2,
   input wire logic                  can_transmit,
   input wire logic                  uart_transmit,
   input wire logic                  ethernet_transmit_data_bit0
);
   import pfs_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire [2:0] m11 = fields.pin11_function_field;
   wire [2:0] m10 = fields.pin10_function_field;
   wire [5:0] wlo = {apb_req.pwdata[6:4], apb_req.pwdata[2:0]};
   sequence s_wr;
      apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 32'h0;
   endsequence
   a_rsvd_zero: assert property ((apb_rsp.prdata & 32'hffff8888) == 32'h0)
      else $error("reserved bits set");
   a_p11_select: assert property (m11 == 3'h1 |-> pin11_oe && pin11_out == chip_select_1)
      else $error("pin 11 select");
   a_p11_input: assert property (m11 > 3'h1 |-> !pin11_oe)
      else $error("pin 11 driven");
   a_p10_select: assert property (m10 == 3'h1 |-> pin10_oe && pin10_out == chip_select_2)
      else $error("pin 10 select");
   a_p10_output: assert property (m10 > 3'h4 |-> pin10_oe && pin10_out ==
      (m10[1] ? (m10[0] ? ethernet_transmit_data_bit0 : uart_transmit) : can_transmit))
      else $error("pin 10 output");
   a_reset_port: assert property (disable iff (1'b0) !rstn ##1 !rstn |-> fields == '0)
      else $error("fields not cleared");
   a_field_store: assert property (s_wr |=> fields[5:0] == $past(wlo))
      else $error("low fields not stored");
endmodule : pfs_chk
bind pfs_top pfs_chk u_chk (.*);

// ---- verif/pfs_top_tb.sv ----
`timescale 1ns/10ps
module pfs_top_tb;
   import pfs_pkg::*;
   pfs_apb_req_t apb_req;
   pfs_apb_rsp_t apb_rsp;
   pfs_fields_t  fields;
   logic [6:0]   lvl;
   logic [31:0]  r;
   logic mclk, rstn, pin11_out, pin11_oe, pin10_out, pin10_oe, port_pin_11_out, port_pin_11_oe;
   logic port_pin_11_in, port_pin_10_out, port_pin_10_oe, port_pin_10_in, interrupt_request_1;
   logic interrupt_request_2, timer_capture_input_v, timer_capture_input_w, can_receive;
   logic uart_receive, ethernet_transmit_enable, pin11_in, pin10_in, chip_select_1;
   logic chip_select_2, can_transmit, uart_transmit, ethernet_transmit_data_bit0;
   int n_errors, n_tests;
   assign {pin11_in, pin10_in, ethernet_transmit_data_bit0, uart_transmit, can_transmit,
      chip_select_2, chip_select_1} = lvl;
   pfs_peer PEER (.*);
   pfs_top DUT (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t bad value", $time);
      end
   endtask : chk
   // Bit 0 of r also carries the error response.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      apb_req <= '{{20'h0, a}, 1'b1, 1'b0, w, d};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
      r = apb_rsp.prdata | {31'h0, apb_rsp.pslverr};
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb
   task automatic t_rw;
      apb(1'b1, 12'h000, 32'h00007777);
      apb(1'b1, 12'h004, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h7777);
   endtask : t_rw
   task automatic t_reset;
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h0);
   endtask : t_reset
   task automatic t_modes;
      logic [2:0]  k;
      logic [12:0] g, x;
      logic [6:0]  v;
      for (int i = 0; i < 8; i++) begin
         if (i == 2) begin
            continue;
         end
         k = 3'(i);
         apb(1'b1, 12'h000, {17'h0, k, 1'b0, k, 8'h00});
         do @(posedge mclk); while (lvl[4:0] !== 5'h08);
         v = lvl;
         g = {pin11_oe, pin10_oe, interrupt_request_1, timer_capture_input_v, can_receive,
            uart_receive, ethernet_transmit_enable, interrupt_request_2, timer_capture_input_w,
            port_pin_11_in, port_pin_10_in, pin11_out, pin10_out};
         x = {k < 3'h2, k < 3'h2 || k > 3'h4, k == 3'h3 && v[6], k == 3'h4 && v[6],
            k != 3'h5 || v[6], k != 3'h6 || v[6], k == 3'h7 && v[6], k == 3'h3 && v[5],
            k == 3'h4 && v[5], v[6], v[5], k == 3'h0 || (k == 3'h1 && v[0]),
            k == 3'h0 || (k == 3'h1 && v[1]) || (k == 3'h5 && v[2]) || (k == 3'h6 && v[3])
            || (k == 3'h7 && v[4])};
         chk({19'h0, g}, {19'h0, x});
      end
   endtask : t_modes
   task automatic conclude;
      $display("errors %0d of %0d checks", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
   initial begin
      rstn = 1'b0;
      apb_req = '0;
      {port_pin_11_out, port_pin_11_oe, port_pin_10_out, port_pin_10_oe} = 4'hf;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_rw();
      t_reset();
      t_modes();
      conclude();
   end
endmodule : pfs_top_tb
